// ==== xd_pkg.sv ====
package xd_pkg;
	// -----------------------------------------------------------------
	// widths and reset values
	// -----------------------------------------------------------------
	localparam int          FILE_AW      = 12;
	localparam int          PC_W         = 20;
	localparam int          REG_AW       = 3;
	localparam logic [7:0]  ACC_RESET    = 8'h00;
	localparam logic [3:0]  BANK_RESET   = 4'h0;
	localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
	localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
	localparam logic [3:0]  ACCESS_LOW   = 4'h0;
	localparam logic [11:0] PORT_FIRST   = 12'hf80;
	localparam logic [11:0] PORT_LAST    = 12'hf8f;
	localparam logic [11:0] TIMER0_ADDR  = 12'hfd0;

	// -----------------------------------------------------------------
	// register port offsets
	// -----------------------------------------------------------------
	localparam logic [2:0] RA_CTRL   = 3'h0;
	localparam logic [2:0] RA_BANK   = 3'h1;
	localparam logic [2:0] RA_ACC    = 3'h2;
	localparam logic [2:0] RA_FLAGS  = 3'h3;
	localparam logic [2:0] RA_PROD_L = 3'h4;
	localparam logic [2:0] RA_PROD_H = 3'h5;
	localparam logic [2:0] RA_SHADOW = 3'h6;

	// -----------------------------------------------------------------
	// opcodes
	// -----------------------------------------------------------------
	localparam logic [3:0] NIB_MOVE  = 4'hc;
	localparam logic [3:0] NIB_WORD2 = 4'hf;
	localparam logic [3:0] NIB_BTOG  = 4'h7;
	localparam logic [3:0] NIB_BSET  = 4'h8;
	localparam logic [3:0] NIB_BCLR  = 4'h9;
	localparam logic [3:0] NIB_BTSS  = 4'ha;
	localparam logic [3:0] NIB_BTSC  = 4'hb;
	localparam logic [4:0] OP5_BRA   = 5'h1a;
	localparam logic [4:0] OP5_BCC   = 5'h1c;
	localparam logic [6:0] OP7_CALL  = 7'h76;
	localparam logic [7:0] OP8_GOTO  = 8'hef;
	localparam logic [7:0] OP8_ADDL  = 8'h0f;
	localparam logic [7:0] OP8_ANDL  = 8'h0b;
	localparam logic [7:0] OP8_IORL  = 8'h09;
	localparam logic [6:0] OP7_MUL   = 7'h01;
	localparam logic [6:0] OP7_CPLT  = 7'h30;
	localparam logic [6:0] OP7_CPEQ  = 7'h31;
	localparam logic [6:0] OP7_CPGT  = 7'h32;
	localparam logic [6:0] OP7_TST   = 7'h33;
	localparam logic [6:0] OP7_SETF  = 7'h34;
	localparam logic [6:0] OP7_CLRF  = 7'h35;
	localparam logic [6:0] OP7_NEG   = 7'h36;
	localparam logic [6:0] OP7_MOVWF = 7'h37;
	localparam logic [5:0] OP6_ADD   = 6'h09;
	localparam logic [5:0] OP6_ADDC  = 6'h08;
	localparam logic [5:0] OP6_SUB   = 6'h17;
	localparam logic [5:0] OP6_SUBB  = 6'h16;
	localparam logic [5:0] OP6_SUBFB = 6'h15;
	localparam logic [5:0] OP6_OR    = 6'h04;
	localparam logic [5:0] OP6_AND   = 6'h05;
	localparam logic [5:0] OP6_XOR   = 6'h06;
	localparam logic [5:0] OP6_COM   = 6'h07;
	localparam logic [5:0] OP6_RLC   = 6'h0d;
	localparam logic [5:0] OP6_RRC   = 6'h0c;
	localparam logic [5:0] OP6_RL    = 6'h11;
	localparam logic [5:0] OP6_RR    = 6'h10;
	localparam logic [5:0] OP6_INC   = 6'h0a;
	localparam logic [5:0] OP6_DEC   = 6'h01;
	localparam logic [5:0] OP6_INCSZ = 6'h0f;
	localparam logic [5:0] OP6_INCSN = 6'h12;
	localparam logic [5:0] OP6_DECSZ = 6'h0b;
	localparam logic [5:0] OP6_DECSN = 6'h13;
	localparam logic [5:0] OP6_MOVF  = 6'h14;
	localparam logic [5:0] OP6_SWAP  = 6'h0e;

	// flag masks, bit order {n, ov, z, dc, c}
	localparam logic [4:0] FL_NONE = 5'h00;
	localparam logic [4:0] FL_ALL  = 5'h1f;
	localparam logic [4:0] FL_ZN   = 5'h14;
	localparam logic [4:0] FL_CZN  = 5'h15;
	localparam logic [4:0] FL_Z    = 5'h04;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} xd_flags_t;

	typedef enum logic [4:0] {
		ALU_PASS, ALU_MOVE, ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB,
		ALU_SUBFB, ALU_NEG, ALU_INC, ALU_DEC, ALU_OR, ALU_AND, ALU_XOR,
		ALU_COM, ALU_RLC, ALU_RRC, ALU_RL, ALU_RR, ALU_SWAP, ALU_ZERO,
		ALU_ONES, ALU_BSET, ALU_BCLR, ALU_BTOG, ALU_ACC
	} xd_alu_op_t;

	typedef enum logic [3:0] {
		SK_NONE, SK_RES_Z, SK_RES_NZ, SK_LT, SK_EQ, SK_GT, SK_OPND_Z,
		SK_BIT_SET, SK_BIT_CLR
	} xd_skip_t;

	typedef enum logic [3:0] {
		CT_NONE, CT_MOVE, CT_WORD2, CT_BRA, CT_BCC, CT_CALL, CT_GOTO,
		CT_MUL, CT_NOP
	} xd_ctl_t;

	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_WORD2 = 3'b010,
		ST_NOP   = 3'b100
	} xd_fsm_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [REG_AW-1:0] addr;
		logic [7:0]        wdata;
	} xd_reg_req_t;

	typedef struct packed {
		logic               en;
		logic [FILE_AW-1:0] addr;
		logic [7:0]         data;
	} xd_file_wr_t;

	typedef struct packed {
		logic            load;
		logic            push;
		logic            rel;
		logic [PC_W-1:0] target;
		logic [10:0]     offset;
	} xd_pc_req_t;

	typedef struct packed {
		xd_fsm_t     fsm;
		logic [7:0]  acc;
		xd_flags_t   flags;
		logic [3:0]  bank;
		logic [15:0] prod;
		logic [7:0]  sh_acc;
		xd_flags_t   sh_flags;
		logic [3:0]  sh_bank;
		logic        presc_assign;
		logic        squash;
		logic        w2_jump;
		logic        w2_call;
		logic        w2_fast;
		logic [7:0]  hold;
		xd_file_wr_t fwr;
		xd_pc_req_t  pc;
		logic        presc_clr;
		logic [7:0]  rdata;
	} xd_state_t;
endpackage

// ==== xd_alu.sv ====
`timescale 1ns/10ps
module xd_alu (
	input  xd_pkg::xd_alu_op_t op,
	input  logic [7:0]         f,
	input  logic [7:0]         w,
	input  logic               cin,
	input  logic [2:0]         bsel,
	output logic [7:0]         res,
	output xd_pkg::xd_flags_t  fl,
	output logic [4:0]         mask
);
	import xd_pkg::*;

	logic [7:0] x;
	logic [7:0] y;
	logic       ci;
	logic       arith;
	logic       c_new;
	logic [8:0] sum;
	logic [4:0] lo;
	logic [7:0] bit_one;

	// one adder serves every arithmetic op; subtraction is add of the
	// complement, so carry reads as "no borrow"
	always_comb begin
		x = f;
		y = 8'h00;
		ci = 1'b0;
		arith = 1'b1;
		unique case (op)
			ALU_ADD:   y = w;
			ALU_ADDC:  begin y = w; ci = cin; end
			ALU_SUB:   begin y = ~w; ci = 1'b1; end
			ALU_SUBB:  begin y = ~w; ci = cin; end
			ALU_SUBFB: begin x = w; y = ~f; ci = cin; end
			ALU_NEG:   begin x = ~f; ci = 1'b1; end
			ALU_INC:   ci = 1'b1;
			ALU_DEC:   y = 8'hff;
			default:   arith = 1'b0;
		endcase
	end

	assign sum = {1'b0, x} + {1'b0, y} + {8'h00, ci};
	assign lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
	assign bit_one = 8'h01 << bsel;

	always_comb begin
		res = f;
		mask = FL_NONE;
		c_new = cin;
		if (arith) begin
			res = sum[7:0];
			mask = FL_ALL;
			c_new = sum[8];
		end else begin
			unique case (op)
				ALU_MOVE: mask = FL_ZN;
				ALU_OR:   begin res = f | w; mask = FL_ZN; end
				ALU_AND:  begin res = f & w; mask = FL_ZN; end
				ALU_XOR:  begin res = f ^ w; mask = FL_ZN; end
				ALU_COM:  begin res = ~f; mask = FL_ZN; end
				ALU_RLC:  begin res = {f[6:0], cin}; c_new = f[7]; mask = FL_CZN; end
				ALU_RRC:  begin res = {cin, f[7:1]}; c_new = f[0]; mask = FL_CZN; end
				ALU_RL:   begin res = {f[6:0], f[7]}; mask = FL_ZN; end
				ALU_RR:   begin res = {f[0], f[7:1]}; mask = FL_ZN; end
				ALU_SWAP: res = {f[3:0], f[7:4]};
				ALU_ZERO: begin res = 8'h00; mask = FL_Z; end
				ALU_ONES: res = 8'hff;
				ALU_BSET: res = f | bit_one;
				ALU_BCLR: res = f & ~bit_one;
				ALU_BTOG: res = f ^ bit_one;
				ALU_ACC:  res = w;
				default:  res = f;
			endcase
		end
	end

	always_comb begin
		fl.c = c_new;
		fl.dc = lo[4];
		fl.z = (res == 8'h00);
		fl.n = res[7];
		fl.ov = (x[7] == y[7]) && (sum[7] != x[7]);
	end
endmodule

// ==== xd_decoder.sv ====
`timescale 1ns/10ps
// Functional notes
// - byte ops: bit 9 clear writes accumulator, set writes file register
// - bit 8 clear uses access bank, set uses bank selector
// - byte and bit ops carry 8-bit file address in bits 7..0
// - two-word move, 12-bit source then 1111 + 12-bit destination, no flags
// - bit ops carry 3-bit bit position in bits 11..9
// - literal ops carry 8-bit immediate in the low byte
// - jump and call: low 8 target bits word one, upper 12 word two
// - call fast bit set saves shadow copies, clear leaves them
// - relative jump carries 11-bit signed offset in bits 10..0
// - conditional branches carry 8-bit signed offset in bits 7..0
// - add group decodes and updates all five arithmetic flags
// - subtract group decodes and updates all five arithmetic flags
// - logic group updates only zero and negative
// - rotates through carry touch C,Z,N; plain rotates touch Z,N
// - increment/decrement update all flags; skip variants change none
// - compare and test skips leave flags unchanged
// - skips take one cycle untaken, two or three when taken
// - multiply finishes in one cycle and changes no flags
// - read-modify-write of a port register reads the pin levels
// - writing timer zero count clears an assigned prescaler
// - relative jump, taken branch or true test costs a second no-op cycle
// - stray second word of a two-word instruction runs as no-op
// - flags are carry, digit carry, zero, overflow, negative
// - multiply product held in product high and product low
module xd_decoder #(
	parameter logic [11:0] PORT_LO  = xd_pkg::PORT_FIRST,
	parameter logic [11:0] PORT_HI  = xd_pkg::PORT_LAST,
	parameter logic [11:0] TIMER_ZERO_COUNT_ADR = xd_pkg::TIMER0_ADDR
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 instr_valid,
	input  wire logic [15:0]          instr,
	output logic                      instr_ready,
	output logic [xd_pkg::FILE_AW-1:0] file_raddr,
	input  wire logic [7:0]           file_rdata,
	input  wire logic [7:0]           port_pins,
	output xd_pkg::xd_file_wr_t       file_wr,
	output xd_pkg::xd_pc_req_t        pc_req,
	output logic                      prescaler_clear,
	input  xd_pkg::xd_reg_req_t       reg_req,
	output logic [7:0]                reg_rdata
);
	import xd_pkg::*;

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_q;
	logic       rst_s_n;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_s_n = rst_q[1];

	// ---------------------------------------------------------------
	// field extraction
	// ---------------------------------------------------------------
	xd_state_t  st;
	xd_state_t  next_st;
	xd_alu_op_t aop;
	xd_skip_t   sk;
	xd_ctl_t    ctl;
	xd_flags_t  afl;
	logic [4:0] amask;
	logic [7:0] res;
	logic [7:0] opnd;
	logic [7:0] fsel;
	logic [11:0] baddr;
	logic [5:0] op6;
	logic [6:0] op7;
	logic       lit;
	logic       dsel;
	logic       wr_f;
	logic       wr_w;
	logic       fl_en;
	logic       rmw;
	logic       port_hit;
	logic       skip_hit;
	logic       bcc_true;
	logic       take;

	assign op6 = instr[15:10];
	assign op7 = instr[15:9];
	assign fsel = instr[7:0];

	// access bank splits low RAM and high special registers
	always_comb begin
		if (instr[8]) begin
			baddr = {st.bank, fsel};
		end else if (fsel >= ACCESS_SPLIT) begin
			baddr = {ACCESS_HIGH, fsel};
		end else begin
			baddr = {ACCESS_LOW, fsel};
		end
	end

	// move source uses a full 12-bit address, everything else is banked
	assign file_raddr = (instr[15:12] == NIB_MOVE) ? instr[11:0] : baddr;
	assign port_hit = (file_raddr >= PORT_LO) && (file_raddr <= PORT_HI);
	assign instr_ready = (st.fsm != ST_NOP);
	assign take = instr_valid && instr_ready;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	always_comb begin
		aop = ALU_PASS;
		sk = SK_NONE;
		ctl = CT_NONE;
		lit = 1'b0;
		dsel = 1'b0;
		wr_f = 1'b0;
		wr_w = 1'b0;
		fl_en = 1'b0;
		if (instr[15:12] == NIB_MOVE) begin
			ctl = CT_MOVE;
		end else if (instr[15:12] == NIB_WORD2) begin
			ctl = CT_WORD2;
		end else if (instr[15:11] == OP5_BRA) begin
			ctl = CT_BRA;
		end else if (instr[15:11] == OP5_BCC) begin
			ctl = CT_BCC;
		end else if (op7 == OP7_CALL) begin
			ctl = CT_CALL;
		end else if (instr[15:8] == OP8_GOTO) begin
			ctl = CT_GOTO;
		end else if (instr[15:8] == OP8_ADDL) begin
			lit = 1'b1; aop = ALU_ADD; wr_w = 1'b1; fl_en = 1'b1;
		end else if (instr[15:8] == OP8_ANDL) begin
			lit = 1'b1; aop = ALU_AND; wr_w = 1'b1; fl_en = 1'b1;
		end else if (instr[15:8] == OP8_IORL) begin
			lit = 1'b1; aop = ALU_OR; wr_w = 1'b1; fl_en = 1'b1;
		end else if (op7 == OP7_MUL) begin
			ctl = CT_MUL;
		end else if (instr[15:12] == 4'h6) begin
			unique case (op7)
				OP7_CPLT:  sk = SK_LT;
				OP7_CPEQ:  sk = SK_EQ;
				OP7_CPGT:  sk = SK_GT;
				OP7_TST:   sk = SK_OPND_Z;
				OP7_SETF:  begin aop = ALU_ONES; wr_f = 1'b1; end
				OP7_CLRF:  begin aop = ALU_ZERO; wr_f = 1'b1; fl_en = 1'b1; end
				OP7_NEG:   begin aop = ALU_NEG; wr_f = 1'b1; fl_en = 1'b1; end
				OP7_MOVWF: begin aop = ALU_ACC; wr_f = 1'b1; end
				default:   ctl = CT_NOP;
			endcase
		end else if (instr[15:12] == NIB_BSET) begin
			aop = ALU_BSET; wr_f = 1'b1;
		end else if (instr[15:12] == NIB_BCLR) begin
			aop = ALU_BCLR; wr_f = 1'b1;
		end else if (instr[15:12] == NIB_BTOG) begin
			aop = ALU_BTOG; wr_f = 1'b1;
		end else if (instr[15:12] == NIB_BTSS) begin
			sk = SK_BIT_SET;
		end else if (instr[15:12] == NIB_BTSC) begin
			sk = SK_BIT_CLR;
		end else begin
			dsel = 1'b1;
			unique case (op6)
				OP6_ADD:   begin aop = ALU_ADD; fl_en = 1'b1; end
				OP6_ADDC:  begin aop = ALU_ADDC; fl_en = 1'b1; end
				OP6_SUB:   begin aop = ALU_SUB; fl_en = 1'b1; end
				OP6_SUBB:  begin aop = ALU_SUBB; fl_en = 1'b1; end
				OP6_SUBFB: begin aop = ALU_SUBFB; fl_en = 1'b1; end
				OP6_OR:    begin aop = ALU_OR; fl_en = 1'b1; end
				OP6_AND:   begin aop = ALU_AND; fl_en = 1'b1; end
				OP6_XOR:   begin aop = ALU_XOR; fl_en = 1'b1; end
				OP6_COM:   begin aop = ALU_COM; fl_en = 1'b1; end
				OP6_RLC:   begin aop = ALU_RLC; fl_en = 1'b1; end
				OP6_RRC:   begin aop = ALU_RRC; fl_en = 1'b1; end
				OP6_RL:    begin aop = ALU_RL; fl_en = 1'b1; end
				OP6_RR:    begin aop = ALU_RR; fl_en = 1'b1; end
				OP6_INC:   begin aop = ALU_INC; fl_en = 1'b1; end
				OP6_DEC:   begin aop = ALU_DEC; fl_en = 1'b1; end
				OP6_INCSZ: begin aop = ALU_INC; sk = SK_RES_Z; end
				OP6_INCSN: begin aop = ALU_INC; sk = SK_RES_NZ; end
				OP6_DECSZ: begin aop = ALU_DEC; sk = SK_RES_Z; end
				OP6_DECSN: begin aop = ALU_DEC; sk = SK_RES_NZ; end
				OP6_MOVF:  begin aop = ALU_MOVE; fl_en = 1'b1; end
				OP6_SWAP:  aop = ALU_SWAP;
				default:   begin dsel = 1'b0; ctl = CT_NOP; end
			endcase
			wr_f = dsel && instr[9];
			wr_w = dsel && !instr[9];
		end
	end

	// a write-back to the same file register reads the pins, so a
	// port bit held low from outside is not restored from its latch
	assign rmw = wr_f && (aop != ALU_ONES) && (aop != ALU_ZERO)
		&& (aop != ALU_ACC);
	assign opnd = lit ? fsel
		: ((rmw && port_hit) ? port_pins : file_rdata);

	xd_alu u_alu (
		.op   (aop),
		.f    (opnd),
		.w    (st.acc),
		.cin  (st.flags.c),
		.bsel (instr[11:9]),
		.res  (res),
		.fl   (afl),
		.mask (amask)
	);

	always_comb begin
		unique case (sk)
			SK_RES_Z:   skip_hit = (res == 8'h00);
			SK_RES_NZ:  skip_hit = (res != 8'h00);
			SK_LT:      skip_hit = (opnd < st.acc);
			SK_EQ:      skip_hit = (opnd == st.acc);
			SK_GT:      skip_hit = (opnd > st.acc);
			SK_OPND_Z:  skip_hit = (opnd == 8'h00);
			SK_BIT_SET: skip_hit = opnd[instr[11:9]];
			SK_BIT_CLR: skip_hit = !opnd[instr[11:9]];
			default:    skip_hit = 1'b0;
		endcase
	end

	// condition bits pick z, c, ov, n; bit 8 inverts the test
	always_comb begin
		unique case (instr[10:9])
			2'b00:   bcc_true = st.flags.z ^ instr[8];
			2'b01:   bcc_true = st.flags.c ^ instr[8];
			2'b10:   bcc_true = st.flags.ov ^ instr[8];
			default: bcc_true = st.flags.n ^ instr[8];
		endcase
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.fwr.en = 1'b0;
		next_st.pc.load = 1'b0;
		next_st.pc.push = 1'b0;
		next_st.pc.rel = 1'b0;
		next_st.presc_clr = 1'b0;
		next_st.rdata = 8'h00;

		// software side; an instruction in the same cycle wins below
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				RA_CTRL:   next_st.rdata = {7'h00, st.presc_assign};
				RA_BANK:   next_st.rdata = {4'h0, st.bank};
				RA_ACC:    next_st.rdata = st.acc;
				RA_FLAGS:  next_st.rdata = {3'h0, st.flags};
				RA_PROD_L: next_st.rdata = st.prod[7:0];
				RA_PROD_H: next_st.rdata = st.prod[15:8];
				RA_SHADOW: next_st.rdata = st.sh_acc;
				default:   next_st.rdata = 8'h00;
			endcase
		end
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				RA_CTRL:  next_st.presc_assign = reg_req.wdata[0];
				RA_BANK:  next_st.bank = reg_req.wdata[3:0];
				RA_ACC:   next_st.acc = reg_req.wdata;
				RA_FLAGS: next_st.flags = xd_flags_t'(reg_req.wdata[4:0]);
				default:  next_st.fsm = st.fsm;
			endcase
		end

		unique case (st.fsm)
			ST_NOP: next_st.fsm = ST_RUN;
			ST_WORD2: if (take) begin
				next_st.fsm = ST_RUN;
				if (ctl == CT_WORD2 && st.w2_jump) begin
					next_st.pc.load = 1'b1;
					next_st.pc.target = {instr[11:0], st.hold};
					next_st.pc.push = st.w2_call;
					if (st.w2_fast) begin
						next_st.sh_acc = st.acc;
						next_st.sh_flags = st.flags;
						next_st.sh_bank = st.bank;
					end
				end else if (ctl == CT_WORD2) begin
					next_st.fwr = '{1'b1, instr[11:0], st.hold};
					next_st.presc_clr = (instr[11:0] == TIMER_ZERO_COUNT_ADR)
						&& st.presc_assign;
				end
			end
			ST_RUN: if (take && st.squash) begin
				// skipped word; a skipped two-word first word leaves its
				// second word to run as a no-op, giving the third cycle
				next_st.squash = 1'b0;
			end else if (take) begin
				unique case (ctl)
					CT_MOVE: begin
						next_st.hold = file_rdata;
						next_st.w2_jump = 1'b0;
						next_st.fsm = ST_WORD2;
					end
					CT_CALL, CT_GOTO: begin
						next_st.hold = fsel;
						next_st.w2_jump = 1'b1;
						next_st.w2_call = (ctl == CT_CALL);
						next_st.w2_fast = (ctl == CT_CALL) && instr[8];
						next_st.fsm = ST_WORD2;
					end
					CT_BRA: begin
						next_st.pc.rel = 1'b1;
						next_st.pc.offset = instr[10:0];
						next_st.fsm = ST_NOP;
					end
					CT_BCC: if (bcc_true) begin
						next_st.pc.rel = 1'b1;
						next_st.pc.offset = {{3{instr[7]}}, instr[7:0]};
						next_st.fsm = ST_NOP;
					end
					CT_MUL: next_st.prod = {8'h00, opnd} * {8'h00, st.acc};
					CT_WORD2, CT_NOP: next_st.fsm = ST_RUN;
					default: begin
						if (wr_w) begin
							next_st.acc = res;
						end
						if (wr_f) begin
							next_st.fwr = '{1'b1, baddr, res};
							next_st.presc_clr = (baddr == TIMER_ZERO_COUNT_ADR)
								&& st.presc_assign;
						end
						if (fl_en) begin
							next_st.flags = xd_flags_t'(
								(st.flags & ~amask) | (afl & amask));
						end
						next_st.squash = skip_hit;
					end
				endcase
			end
			default: next_st.fsm = ST_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			st <= '0;
			st.fsm <= ST_RUN;
			st.acc <= ACC_RESET;
			st.bank <= BANK_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign file_wr = st.fwr;
	assign pc_req = st.pc;
	assign prescaler_clear = st.presc_clr;
	assign reg_rdata = st.rdata;
endmodule

// ==== xd_decoder_monitor.sv ====
`timescale 1ns/10ps
module xd_decoder_monitor
	import xd_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   rst_n,
	input wire logic                   instr_valid,
	input wire logic [15:0]            instr,
	input wire logic                   instr_ready,
	input wire logic [xd_pkg::FILE_AW-1:0] file_raddr,
	input xd_pkg::xd_file_wr_t         file_wr,
	input xd_pkg::xd_pc_req_t          pc_req,
	input wire logic                   prescaler_clear
);
	logic take;
	logic first_w;
	logic prev_first;
	assign take = instr_valid && instr_ready;
	assign first_w = instr[15:12] == NIB_MOVE || instr[15:8] == OP8_GOTO
		|| instr[15:9] == OP7_CALL;
	// a word after a first word is its operand, so most checks skip it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			prev_first <= 1'b0;
		else if (take)
			prev_first <= first_w;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_MOVE_SRC: assert property (take && !prev_first &&
		instr[15:12] == NIB_MOVE |-> file_raddr == instr[11:0])
		else $error("move source address wrong");
	AST_BANK_ACCESS: assert property (take && !prev_first &&
		instr[15:12] inside {[4'h1:4'hb]} && !instr[8] |-> file_raddr ==
		{(instr[7] ? ACCESS_HIGH : ACCESS_LOW), instr[7:0]})
		else $error("access bank address wrong");
	AST_ADD_DEST: assert property (take && !prev_first &&
		instr[15:10] == OP6_ADD |=> file_wr.en == $past(instr[9]))
		else $error("add destination wrong");
	AST_GOTO_TARGET: assert property (take && !prev_first &&
		instr[15:8] == OP8_GOTO ##1 take && instr[15:12] == NIB_WORD2
		|=> pc_req.load && pc_req.target ==
		{$past(instr[11:0]), $past(instr[7:0], 2)})
		else $error("jump target wrong");
	AST_CALL_PUSH: assert property (take && !prev_first &&
		instr[15:9] == OP7_CALL ##1 take && instr[15:12] == NIB_WORD2
		|=> pc_req.push && pc_req.load)
		else $error("call did not push and load");
	AST_STRAY_W2: assert property (take && !prev_first &&
		instr[15:12] == NIB_WORD2 |=> !(file_wr.en || pc_req.load ||
		pc_req.push || pc_req.rel || prescaler_clear))
		else $error("stray second word had an effect");
	AST_BRA: assert property (take && !prev_first &&
		instr[15:11] == OP5_BRA |=> pc_req.rel && !instr_ready &&
		pc_req.offset == $past(instr[10:0]))
		else $error("relative jump wrong");
	AST_READY_GAP: assert property (!instr_ready |->
		pc_req.rel ##1 instr_ready)
		else $error("no-op cycle wrong");
	AST_TIMER_ZERO_COUNT: assert property (prescaler_clear |->
		file_wr.en && file_wr.addr == TIMER0_ADDR)
		else $error("prescaler cleared without timer write");
	cover property (take && instr[15:8] == OP8_GOTO);
	cover property (!instr_ready);
	cover property (prescaler_clear);
endmodule

bind xd_decoder xd_decoder_monitor i_xd_decoder_monitor (
	.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
	.instr(instr), .instr_ready(instr_ready), .file_raddr(file_raddr),
	.file_wr(file_wr), .pc_req(pc_req), .prescaler_clear(prescaler_clear)
);

// ==== xd_file_model.sv ====
`timescale 1ns/10ps
module xd_file_model (
	input wire logic              clk_sys,
	input wire logic [11:0]       file_raddr,
	input xd_pkg::xd_file_wr_t    file_wr,
	output logic [7:0]            file_rdata,
	output logic [7:0]            port_pins
);
	logic [7:0] mem [4096];
	// each location starts as its own low address byte
	initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0];
	assign file_rdata = mem[file_raddr];
	// pins differ from the latch so a latch read shows up
	assign port_pins = 8'ha5;
	always @(posedge clk_sys) begin
		if (file_wr.en) begin
			mem[file_wr.addr] <= file_wr.data;
		end
	end
endmodule

// ==== xd_tb.sv ====
`timescale 1ns/10ps
module tb;
	import xd_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        instr_valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic        instr_ready;
	logic        prescaler_clear;
	logic        ps_seen = 1'b0;
	logic [11:0] file_raddr;
	logic [7:0]  file_rdata;
	logic [7:0]  port_pins;
	logic [7:0]  reg_rdata;
	xd_file_wr_t file_wr;
	xd_pc_req_t  pc_req;
	xd_reg_req_t reg_req = '0;
	int          n_errors = 0;
	int          n_compared = 0;
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (prescaler_clear === 1'b1) ps_seen <= 1'b1;
	xd_decoder i_xd_decoder (.clk_sys(clk_sys), .rst_n(rst_n),
		.instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
		.file_raddr(file_raddr), .file_rdata(file_rdata),
		.port_pins(port_pins), .file_wr(file_wr), .pc_req(pc_req),
		.prescaler_clear(prescaler_clear), .reg_req(reg_req),
		.reg_rdata(reg_rdata));
	xd_file_model i_xd_file_model (.clk_sys(clk_sys),
		.file_raddr(file_raddr), .file_wr(file_wr),
		.file_rdata(file_rdata), .port_pins(port_pins));
	task automatic chk(input string nm, input logic [19:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		reg_req <= '0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys);
		reg_req <= '0;
		#1 chk("reg_rdata", reg_rdata, e);
		@(posedge clk_sys);
	endtask
	// holds the word until it is taken; leaves valid up for the next one
	task automatic ex(input logic [15:0] w);
		instr <= w;
		instr_valid <= 1'b1;
		#1;
		while (instr_ready !== 1'b1) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
	endtask
	task automatic idle;
		instr_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(3'h7, 8'h00);
		wr(RA_ACC, 8'h7f);
		ex(16'h2401);
		idle;
		rd(RA_ACC, 8'h80);
		rd(RA_FLAGS, 8'h1a);
		ex(16'h2601);
		idle;
		chk("file 001", i_xd_file_model.mem[1], 8'h81);
		wr(RA_FLAGS, 8'h0f);
		ex(16'h1401);
		ex(16'h0202);
		idle;
		rd(RA_FLAGS, 8'h1b);
		rd(RA_PROD_L, 8'h00);
		rd(RA_PROD_H, 8'h01);
		ex(16'hc003);
		ex(16'hf020);
		ex(16'hed12);
		ex(16'hf001);
		idle;
		chk("file 020", i_xd_file_model.mem[12'h020], 8'h03);
		wr(RA_ACC, 8'h33);
		ex(16'hec12);
		ex(16'hf001);
		ex(16'hf0ff);
		idle;
		rd(RA_SHADOW, 8'h80);
		rd(RA_ACC, 8'h33);
		ex(16'h6233);
		ex(16'hc001);
		ex(16'hf040);
		ex(16'h2401);
		ex(16'hef34);
		ex(16'hf567);
		ex(16'hd7ff);
		ex(16'h1e80);
		idle;
		chk("file 040", i_xd_file_model.mem[12'h040], 8'h40);
		rd(RA_ACC, 8'hb4);
		chk("file f80", i_xd_file_model.mem[12'hf80], 8'h5a);
		wr(RA_CTRL, 8'h01);
		ex(16'h2ad0);
		idle;
		chk("prescaler", ps_seen, 1'b1);
		wr(RA_BANK, 8'h02);
		ex(16'h2705);
		idle;
		chk("file 205", i_xd_file_model.mem[12'h205], 8'hb9);
		// subtract, rotate, literal, both branch senses, bit and skip ops
		wr(RA_ACC, 8'h05);
		ex(16'h5e10);
		ex(16'h3611);
		ex(16'h0f0d);
		ex(16'he001);
		ex(16'he1fe);
		ex(16'h8a12);
		ex(16'h4e14);
		ex(16'h2a15);
		// a file write lands one edge late, so let it settle before reuse
		idle;
		ex(16'haa12);
		ex(16'h2a13);
		idle;
		chk("file 010", i_xd_file_model.mem[12'h010], 8'h0b);
		chk("file 011", i_xd_file_model.mem[12'h011], 8'h23);
		chk("file 012", i_xd_file_model.mem[12'h012], 8'h32);
		chk("file 013", i_xd_file_model.mem[12'h013], 8'h13);
		chk("file 014", i_xd_file_model.mem[12'h014], 8'h13);
		chk("file 015", i_xd_file_model.mem[12'h015], 8'h15);
		chk("branch offset", pc_req.offset, 11'h7fe);
		chk("jump target", pc_req.target, 20'h56734);
		rd(RA_ACC, 8'h12);
		rd(RA_FLAGS, 8'h02);
		tally_and_finish;
	end
endmodule
